// [core/cdr_pkg.sv]
// Constants, types and register map of the current DAC data and status registers
//==============================================================
package cdr_pkg;
  // Frame layout
  localparam int FRAME_BITS = 24;
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 16;
  // Register and command addresses
  localparam logic [7:0] ADDR_NOP = 8'h00;
  localparam logic [7:0] ADDR_CODE = 8'h01;
  localparam logic [7:0] ADDR_READ = 8'h02;
  localparam logic [7:0] ADDR_RESET = 8'h56;
  localparam logic [7:0] ADDR_GAIN = 8'h58;
  localparam logic [7:0] ADDR_OFFSET = 8'h59;
  localparam logic [7:0] ADDR_STATUS = 8'h5A;
  // Field positions and reset values
  localparam int RESET_BIT = 0;
  localparam int STATUS_USED = 5;
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [15:0] GAIN_RST = 16'h0000;
  localparam logic [15:0] OFFSET_RST = 16'h0000;
  localparam logic [15:0] MAX_CODE = 16'hFFFF;
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int MON_TIME_NS = 10000;
  localparam int MON_CYCLES = (MON_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : MON_TIME_NS / CLK_PERIOD_NS;
  // Serial frame
  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] data;
  } cdr_frame_s;
  // Status word, low to high: temp, slew, load, watchdog, frame check
  typedef struct packed {
    logic [DATA_BITS-STATUS_USED-1:0] reserved;
    logic frameCheckFault;
    logic watchdogFault;
    logic loadFault;
    logic slewingActive;
    logic overTempFault;
  } cdr_status_s;
endpackage : cdr_pkg

// [core/cdr_regs.sv]
// Register bank of the current DAC: serial slave, code, trims, soft reset, status
`timescale 1ns/1ps
module cdr_regs #(
  parameter int RES_BITS = 16,
  parameter int MON_PERIOD = cdr_pkg::MON_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial link
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  output logic miso,
  output logic misoOeN,
  // Configuration inputs
  input wire logic userTrimEnable,
  input wire logic rampEnable,
  // Fault and slewing sources on this clock
  input wire logic frameCheckFaultIn,
  input wire logic watchdogFaultIn,
  input wire logic slewActiveIn,
  // Analog monitor pins
  input wire logic loadFaultIn,
  input wire logic overTempIn,
  // Register contents
  output logic [cdr_pkg::DATA_BITS-1:0] outputCode,
  output logic [cdr_pkg::DATA_BITS-1:0] gainTrim,
  output logic [cdr_pkg::DATA_BITS-1:0] offsetTrim,
  output logic [cdr_pkg::DATA_BITS-1:0] adjustedCode,
  output cdr_pkg::cdr_status_s alarmStatus,
  output logic softResetPulse
);
  import cdr_pkg::*;

  //==============================================================
  // Link domain: shift in frames on sclk
  logic spiRst;
  logic [4:0] bitCnt_q;
  logic [FRAME_BITS-1:0] rxShift_q;
  cdr_frame_s rxFrame_q;
  logic rxTgl_q;
  logic [FRAME_BITS-1:0] txWord;
  logic misoBit_q;
  logic [DATA_BITS-1:0] readData_q;

  // Frame logic rests while select is high
  // Select rising mid frame drops the partial frame
  assign spiRst = reset | csN;

  // Bit counter and shifter
  always_ff @(posedge sclk or posedge spiRst) begin
    if (spiRst) begin
      bitCnt_q <= 5'h00;
      rxShift_q <= '0;
    end else begin
      rxShift_q <= {rxShift_q[FRAME_BITS-2:0], mosi};
      bitCnt_q <= (bitCnt_q == 5'(FRAME_BITS - 1)) ? 5'h00 : bitCnt_q + 5'h01;
    end
  end

  // Completed frame held and announced by toggle
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      rxFrame_q <= '0;
      rxTgl_q <= 1'b0;
    end else if (!csN && bitCnt_q == 5'(FRAME_BITS - 1)) begin
      rxFrame_q <= {rxShift_q[FRAME_BITS-2:0], mosi};
      rxTgl_q <= ~rxTgl_q;
    end
  end

  // Readback word, stable between frames
  assign txWord = {{ADDR_BITS{1'b0}}, readData_q};

  // Output bit changes on falling edge
  always_ff @(negedge sclk or posedge spiRst) begin
    if (spiRst) begin
      misoBit_q <= 1'b0;
    end else begin
      misoBit_q <= txWord[5'(FRAME_BITS - 1) - bitCnt_q];
    end
  end

  assign miso = misoBit_q;
  assign misoOeN = csN;

  //==============================================================
  // Crossings into clk domain
  logic [2:0] tglSync_q;
  logic [1:0] loadSync_q;
  logic [1:0] tempSync_q;
  logic frameStrobe;

  // Toggle synchroniser plus edge stage
  // Load and temp chains feed logic from their second stage; the toggle chain from its second and third
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tglSync_q <= 3'h0;
      loadSync_q <= 2'h0;
      tempSync_q <= 2'h0;
    end else begin
      tglSync_q <= {tglSync_q[1:0], rxTgl_q};
      loadSync_q <= {loadSync_q[0], loadFaultIn};
      tempSync_q <= {tempSync_q[0], overTempIn};
    end
  end

  // Frame word stays put while its toggle travels
  assign frameStrobe = tglSync_q[2] ^ tglSync_q[1];

  //==============================================================
  // Decode and register writes
  cdr_frame_s frame;
  logic softResetReq_q;
  logic [DATA_BITS-1:0] lowMask;
  logic [DATA_BITS-1:0] outputCode_q;
  logic [DATA_BITS-1:0] gainTrim_q;
  logic [DATA_BITS-1:0] offsetTrim_q;

  assign frame = rxFrame_q;
  assign lowMask = ~((DATA_BITS'(1) << (DATA_BITS - RES_BITS)) - DATA_BITS'(1));

  // Write decode used by several registers
  function automatic logic isWrite(input logic strobe, input logic [7:0] a, input logic [7:0] want);
    isWrite = strobe && (a == want);
  endfunction : isWrite

  // Soft reset request, one cycle then self clears
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      softResetReq_q <= 1'b0;
    end else begin
      softResetReq_q <= isWrite(frameStrobe, frame.addr, ADDR_RESET) && frame.data[RESET_BIT];
    end
  end

  assign softResetPulse = softResetReq_q;

  // Code and trim registers, low bits dropped when narrow
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      outputCode_q <= CODE_RST;
      gainTrim_q <= GAIN_RST;
      offsetTrim_q <= OFFSET_RST;
    end else if (softResetReq_q) begin
      outputCode_q <= CODE_RST;
      gainTrim_q <= GAIN_RST;
      offsetTrim_q <= OFFSET_RST;
    end else begin
      if (isWrite(frameStrobe, frame.addr, ADDR_CODE)) begin
        outputCode_q <= frame.data & lowMask;
      end
      if (isWrite(frameStrobe, frame.addr, ADDR_GAIN)) begin
        gainTrim_q <= frame.data & lowMask;
      end
      if (isWrite(frameStrobe, frame.addr, ADDR_OFFSET)) begin
        offsetTrim_q <= frame.data & lowMask;
      end
    end
  end

  assign outputCode = outputCode_q;
  assign gainTrim = gainTrim_q;
  assign offsetTrim = offsetTrim_q;

  //==============================================================
  // Monitoring cycle and alarm flags
  logic [15:0] monCnt_q;
  logic monTick;
  cdr_status_s status_q;

  // Free running monitor period
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      monCnt_q <= 16'h0000;
    end else begin
      monCnt_q <= (monCnt_q == 16'(MON_PERIOD - 1)) ? 16'h0000 : monCnt_q + 16'h0001;
    end
  end

  assign monTick = (monCnt_q == 16'(MON_PERIOD - 1));

  // Flags follow their cause each tick; soft reset clears until next tick
  // Soft reset wins over a tick in the same cycle
  // Slewing is live status, not an alarm, so soft reset keeps it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_q <= '0;
    end else begin
      status_q.reserved <= '0;
      status_q.slewingActive <= slewActiveIn & rampEnable;
      if (softResetReq_q) begin
        status_q.frameCheckFault <= 1'b0;
        status_q.watchdogFault <= 1'b0;
        status_q.loadFault <= 1'b0;
        status_q.overTempFault <= 1'b0;
      end else if (monTick) begin
        status_q.frameCheckFault <= frameCheckFaultIn;
        status_q.watchdogFault <= watchdogFaultIn;
        status_q.loadFault <= loadSync_q[1];
        status_q.overTempFault <= tempSync_q[1];
      end
    end
  end

  assign alarmStatus = status_q;

  //==============================================================
  // Readback selection
  // Word reaches the link quasi statically between frames
  // Unknown read targets return zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readData_q <= '0;
    end else if (softResetReq_q) begin
      readData_q <= '0;
    end else if (isWrite(frameStrobe, frame.addr, ADDR_READ)) begin
      case (frame.data[ADDR_BITS-1:0])
        ADDR_CODE: readData_q <= outputCode_q;
        ADDR_GAIN: readData_q <= gainTrim_q;
        ADDR_OFFSET: readData_q <= offsetTrim_q;
        ADDR_STATUS: readData_q <= status_q;
        default: readData_q <= '0;
      endcase
    end
  end

  //==============================================================
  // Calibrated code: code * (1 + gain/65536) + signed offset, saturated
  logic [DATA_BITS:0] gainFactor;
  logic [2*DATA_BITS:0] product;
  logic signed [DATA_BITS+2:0] sum;
  logic [DATA_BITS-1:0] calCode;
  logic [DATA_BITS-1:0] adjusted_q;

  assign gainFactor = {1'b1, gainTrim_q};
  assign product = (2*DATA_BITS+1)'(outputCode_q) * (2*DATA_BITS+1)'(gainFactor);
  assign sum = $signed({2'b00, product[2*DATA_BITS:DATA_BITS]})
             + $signed({{3{offsetTrim_q[DATA_BITS-1]}}, offsetTrim_q});

  // Clamp to the code range
  // Gain of zero is unity; offset is two's complement
  always_comb begin
    if (sum < 0) begin
      calCode = CODE_RST;
    end else if (sum > $signed({3'b000, MAX_CODE})) begin
      calCode = MAX_CODE;
    end else begin
      calCode = sum[DATA_BITS-1:0];
    end
  end

  // Trim applied only when enabled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      adjusted_q <= CODE_RST;
    end else begin
      adjusted_q <= userTrimEnable ? (calCode & lowMask) : outputCode_q;
    end
  end

  assign adjustedCode = adjusted_q;

  //==============================================================
  // Assertions

  // Soft reset bit lasts one cycle
  a_soft_selfclear: assert property (@(posedge clk) disable iff (reset)
    softResetReq_q |=> !softResetReq_q)
    else $error("soft reset bit stuck");
  // Soft reset returns registers to defaults
  a_soft_defaults: assert property (@(posedge clk) disable iff (reset)
    softResetReq_q |=> (outputCode_q == CODE_RST && gainTrim_q == GAIN_RST && offsetTrim_q == OFFSET_RST))
    else $error("soft reset left register set");
  // Soft reset clears the frame check, load and temperature flags
  a_soft_flags: assert property (@(posedge clk) disable iff (reset)
    softResetReq_q |=> !(status_q.frameCheckFault || status_q.loadFault || status_q.overTempFault))
    else $error("alarm flag survived reset");
  // Watchdog flag cleared by soft reset
  a_wd_reset: assert property (@(posedge clk) disable iff (reset)
    softResetReq_q |=> !status_q.watchdogFault)
    else $error("watchdog flag survived reset");
  // Reserved reset bits raise no request
  a_reset_reserved: assert property (@(posedge clk) disable iff (reset)
    (isWrite(frameStrobe, frame.addr, ADDR_RESET) && !frame.data[RESET_BIT]) |=> !softResetReq_q)
    else $error("reset without bit zero");

  // Code write lands masked
  a_code_write: assert property (@(posedge clk) disable iff (reset)
    (isWrite(frameStrobe, frame.addr, ADDR_CODE) && !softResetReq_q)
      |=> outputCode_q == ($past(frame.data) & lowMask))
    else $error("code write lost");
  // Gain trim write lands masked
  a_gain_write: assert property (@(posedge clk) disable iff (reset)
    (isWrite(frameStrobe, frame.addr, ADDR_GAIN) && !softResetReq_q)
      |=> gainTrim_q == ($past(frame.data) & lowMask))
    else $error("gain write lost");
  // Offset trim write lands masked
  a_offset_write: assert property (@(posedge clk) disable iff (reset)
    (isWrite(frameStrobe, frame.addr, ADDR_OFFSET) && !softResetReq_q)
      |=> offsetTrim_q == ($past(frame.data) & lowMask))
    else $error("offset write lost");
  // Narrow variant keeps no low bits
  a_narrow_low: assert property (@(posedge clk) disable iff (reset)
    ((outputCode_q | gainTrim_q | offsetTrim_q) & ~lowMask) == '0)
    else $error("low bits kept");
  // Trimmed code keeps no low bits
  a_cal_narrow: assert property (@(posedge clk) disable iff (reset)
    (adjusted_q & ~lowMask) == '0)
    else $error("trimmed low bits kept");

  // Status readback copies the flags
  a_read_status: assert property (@(posedge clk) disable iff (reset)
    (isWrite(frameStrobe, frame.addr, ADDR_READ) && frame.data[ADDR_BITS-1:0] == ADDR_STATUS && !softResetReq_q)
      |=> readData_q == $past(status_q))
    else $error("status readback wrong");
  // Reserved status bits stay zero
  a_status_rsvd: assert property (@(posedge clk) disable iff (reset)
    status_q.reserved == '0)
    else $error("reserved status bits set");

  // Frame check flag set at tick
  a_frame_flag: assert property (@(posedge clk) disable iff (reset)
    (monTick && !softResetReq_q && frameCheckFaultIn) |=> status_q.frameCheckFault)
    else $error("frame fault not flagged");
  // Frame check flag drops when resolved
  a_frame_clear: assert property (@(posedge clk) disable iff (reset)
    (monTick && !softResetReq_q && !frameCheckFaultIn) |=> !status_q.frameCheckFault)
    else $error("frame fault kept after resolution");
  // Watchdog flag follows its cause at tick
  a_wd_flag: assert property (@(posedge clk) disable iff (reset)
    (monTick && !softResetReq_q) |=> status_q.watchdogFault == $past(watchdogFaultIn))
    else $error("watchdog flag not sampled");
  // Load flag sampled at tick
  a_load_sample: assert property (@(posedge clk) disable iff (reset)
    (monTick && !softResetReq_q) |=> status_q.loadFault == $past(loadSync_q[1]))
    else $error("load flag not sampled");
  // Temperature flag sampled at tick
  a_temp_sample: assert property (@(posedge clk) disable iff (reset)
    (monTick && !softResetReq_q) |=> status_q.overTempFault == $past(tempSync_q[1]))
    else $error("temp flag not sampled");
  // Alarm flags hold between ticks
  a_flags_hold: assert property (@(posedge clk) disable iff (reset)
    (!monTick && !softResetReq_q)
      |=> $stable({status_q.frameCheckFault, status_q.watchdogFault, status_q.loadFault, status_q.overTempFault}))
    else $error("alarm flag moved between ticks");
  // Temperature flag kept until tick or reset
  a_temp_clear: assert property (@(posedge clk) disable iff (reset)
    (status_q.overTempFault && !monTick && !softResetReq_q) |=> status_q.overTempFault)
    else $error("temp flag dropped early");
  // Monitor counter stays in its period
  a_mon_range: assert property (@(posedge clk) disable iff (reset)
    monCnt_q < 16'(MON_PERIOD))
    else $error("monitor counter out of range");

  // Slewing flag gated by ramp enable
  a_slew_follow: assert property (@(posedge clk) disable iff (reset)
    !rampEnable |=> !status_q.slewingActive)
    else $error("slewing without ramp");
  // Slewing flag tracks the slew engine
  a_slew_track: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> status_q.slewingActive == $past(slewActiveIn && rampEnable))
    else $error("slewing flag not tracking");
  // Trim bypassed while disabled
  a_cal_bypass: assert property (@(posedge clk) disable iff (reset)
    !userTrimEnable |=> adjusted_q == $past(outputCode_q))
    else $error("trim applied while off");

  // Main scenarios reached
  c_code_write: cover property (@(posedge clk) isWrite(frameStrobe, frame.addr, ADDR_CODE));
  c_soft_reset: cover property (@(posedge clk) softResetReq_q);
  c_readback: cover property (@(posedge clk) isWrite(frameStrobe, frame.addr, ADDR_READ));
  c_load_alarm: cover property (@(posedge clk) status_q.loadFault);
  c_temp_alarm: cover property (@(posedge clk) status_q.overTempFault);
endmodule : cdr_regs

// [dv/cdr_spi_host.sv]
// Serial host model that frames register writes and readbacks
`timescale 1ns/1ps
module cdr_spi_host (
  // Serial link
  output logic sclk,
  output logic csN,
  output logic mosi,
  input wire logic miso,
  input wire logic misoOeN
);
  import cdr_pkg::*;
  logic lastMiso;
  logic misoLine;
  // Released data line shows the inverse of its last value
  assign misoLine = misoOeN ? ~lastMiso : miso;
  // Idle link, clock standing still
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
    lastMiso = 1'b0;
  end
  // One frame MSB first, 64 ns link period, gap covers readback crossing
  task automatic xfer(input cdr_frame_s tx, output logic [FRAME_BITS-1:0] rx);
    csN = 1'b0;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      mosi = tx[i];
      #32 sclk = 1'b1;
      rx[i] = misoLine;
      if (!misoOeN) lastMiso = miso;
      #32 sclk = 1'b0;
    end
    #32 csN = 1'b1;
    mosi = ~mosi;
    #400;
  endtask : xfer
  // Soft reset request as a write to the reset location
  task automatic swReset;
    logic [FRAME_BITS-1:0] rx;
    xfer({ADDR_RESET, 16'h0001}, rx);
  endtask : swReset
endmodule : cdr_spi_host

// [dv/test_current_dac_data_status_regs.sv]
// Self-checking bench of the current DAC data and status registers
`timescale 1ns/1ps
module test_current_dac_data_status_regs;
  import cdr_pkg::*;
  logic clk, reset, sclk, csN, mosi, miso, misoOeN, prevPulse;
  logic userTrimEnable, rampEnable, frameCheckFaultIn, watchdogFaultIn, slewActiveIn, loadFaultIn, overTempIn;
  logic [DATA_BITS-1:0] outputCode, gainTrim, offsetTrim, adjustedCode, narrowCode, rd16, snap;
  logic [FRAME_BITS-1:0] rx;
  cdr_status_s alarmStatus;
  logic softResetPulse;
  int err_count, num_checks, pulses;
  // Full and narrow variants share the link
  cdr_regs #(.RES_BITS(16), .MON_PERIOD(4)) u_cdr_regs (.clk(clk), .reset(reset), .sclk(sclk), .csN(csN),
    .mosi(mosi), .miso(miso), .misoOeN(misoOeN), .userTrimEnable(userTrimEnable), .rampEnable(rampEnable),
    .frameCheckFaultIn(frameCheckFaultIn), .watchdogFaultIn(watchdogFaultIn), .slewActiveIn(slewActiveIn),
    .loadFaultIn(loadFaultIn), .overTempIn(overTempIn), .outputCode(outputCode), .gainTrim(gainTrim),
    .offsetTrim(offsetTrim), .adjustedCode(adjustedCode), .alarmStatus(alarmStatus),
    .softResetPulse(softResetPulse));
  cdr_regs #(.RES_BITS(12), .MON_PERIOD(4)) u_cdr_regs_narrow (.clk(clk), .reset(reset), .sclk(sclk),
    .csN(csN), .mosi(mosi), .miso(), .misoOeN(), .userTrimEnable(userTrimEnable), .rampEnable(rampEnable),
    .frameCheckFaultIn(frameCheckFaultIn), .watchdogFaultIn(watchdogFaultIn), .slewActiveIn(slewActiveIn),
    .loadFaultIn(loadFaultIn), .overTempIn(overTempIn), .outputCode(narrowCode), .gainTrim(),
    .offsetTrim(), .adjustedCode(), .alarmStatus(), .softResetPulse());
  cdr_spi_host u_cdr_spi_host (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso), .misoOeN(misoOeN));
  // 20 MHz system clock
  always #25 clk = ~clk;
  // Count soft reset pulses and snapshot state one cycle after each
  always @(negedge clk) begin
    if (prevPulse === 1'b1) snap = outputCode | alarmStatus;
    if (softResetPulse === 1'b1) pulses++;
    prevPulse = softResetPulse;
  end
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_cdr_spi_host.xfer({a, d}, rx);
  endtask : wr
  // Read command, then a no-op frame that shifts the word out
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    u_cdr_spi_host.xfer({ADDR_READ, 8'h00, a}, rx);
    u_cdr_spi_host.xfer({ADDR_NOP, 16'h0000}, rx);
    d = rx[15:0];
    chk({8'h00, rx[23:16]}, 16'h0000, "readback pad");
  endtask : rd
  task automatic t_reset;
    chk(outputCode, CODE_RST, "code default");
    chk(gainTrim, GAIN_RST, "gain default");
    chk(offsetTrim, OFFSET_RST, "offset default");
    chk(alarmStatus, 16'h0000, "status default");
    $display("test reset done");
  endtask : t_reset
  // Writes, readbacks, narrow masking and trim arithmetic
  task automatic t_regs;
    wr(ADDR_CODE, 16'h1234);
    wr(ADDR_GAIN, 16'h8000);
    wr(ADDR_OFFSET, 16'hFFF0);
    chk(outputCode, 16'h1234, "code");
    chk(gainTrim, 16'h8000, "gain");
    chk(offsetTrim, 16'hFFF0, "offset");
    chk(narrowCode, 16'h1230, "narrow code");
    rd(ADDR_CODE, rd16);
    chk(rd16, 16'h1234, "code readback");
    rd(ADDR_GAIN, rd16);
    chk(rd16, 16'h8000, "gain readback");
    rd(ADDR_OFFSET, rd16);
    chk(rd16, 16'hFFF0, "offset readback");
    chk(adjustedCode, 16'h1234, "trim bypass");
    @(negedge clk) userTrimEnable = 1'b1;
    repeat (4) @(negedge clk);
    // 0x1234 * 1.5 = 0x1B4E, minus 16
    chk(adjustedCode, 16'h1B3E, "trimmed code");
    $display("test regs done");
  endtask : t_regs
  // Fault flags follow their causes at monitor ticks
  task automatic t_status;
    @(negedge clk) {frameCheckFaultIn, watchdogFaultIn, slewActiveIn, loadFaultIn, overTempIn} = 5'h1F;
    repeat (16) @(negedge clk);
    chk(alarmStatus, 16'h001D, "ramp off");
    rampEnable = 1'b1;
    repeat (16) @(negedge clk);
    chk(alarmStatus, 16'h001F, "all flags");
    rd(ADDR_STATUS, rd16);
    chk(rd16, 16'h001F, "status readback");
    @(negedge clk) {loadFaultIn, overTempIn} = 2'b00;
    repeat (16) @(negedge clk);
    chk(alarmStatus, 16'h001A, "resolved");
    loadFaultIn = 1'b1;
    $display("test status done");
  endtask : t_status
  // Ignored frames, then soft reset and reassertion
  task automatic t_soft;
    wr(8'h77, 16'hBEEF);
    wr(ADDR_RESET, 16'hFFFE);
    chk(outputCode, 16'h1234, "no reset effect");
    chk(16'(pulses), 16'h0000, "no pulse");
    u_cdr_spi_host.swReset();
    chk(outputCode, CODE_RST, "code after reset");
    chk(gainTrim, GAIN_RST, "gain after reset");
    // Code and alarm flags clear; slewing is live status and stays
    chk(snap, 16'h0002, "cleared after reset");
    chk(16'(pulses), 16'h0001, "single pulse");
    repeat (16) @(negedge clk);
    chk(alarmStatus, 16'h001E, "reasserted");
    chk(16'(pulses), 16'h0001, "bit self cleared");
    $display("test soft reset done");
  endtask : t_soft
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    {clk, reset, prevPulse, userTrimEnable, rampEnable} = 5'b01000;
    {frameCheckFaultIn, watchdogFaultIn, slewActiveIn, loadFaultIn, overTempIn} = 5'h00;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    t_reset();
    t_regs();
    t_status();
    t_soft();
    report_and_stop();
  end
  // Watchdog
  initial begin
    #300000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule : test_current_dac_data_status_regs
